/* dv/ptr_buzzer_model.sv */
`timescale 1ns/1ps

// Buzzer on the open-drain tone pin, with its pull-up resistor
module ptr_buzzer_model (
    input  wire logic toneOut,
    input  wire logic toneOutEnN,
    output logic      buzPin
);
    // Pin rests at the pull-up level unless the device sinks it
    assign buzPin = toneOutEnN ? 1'b1 : toneOut;
endmodule : ptr_buzzer_model

/* dv/ptr_tone_ref_tb.sv */
`timescale 1ns/1ps
`include "ptr_defs.svh"

module ptr_tone_ref_tb;
    import ptr_pkg::*;
    // Short half periods so every frequency is seen quickly
    localparam int HRT = 4, HF32 = 6, HF76 = 7, H64 = 8, H16 = 10, HSL = 12;
    localparam int HT2K = 20, HT4K = 14, HT3K2 = 16, HT2K7 = 18;
    localparam int B_EXP [5] = '{HF32, H64, H16, HSL, HF76};
    localparam int T_EXP [4] = '{HT2K, HT4K, HT3K2, HT2K7};

    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        toneSelPinA, toneSelPinB, rfPowerCtl, alertEnableIn, outBEnableIn;
    logic        refClkOutA, refClkOutB, toneOut, toneOutEnN, battLowFlagOut, irq, buzPin;
    int          nFail, totalChecks, cycles, h;
    ptr_ctrl_t   cfg;

    ptr_tone_ref #(
        .HALF_RT(33'(HRT)), .HALF_F32(33'(HF32)), .HALF_F76(33'(HF76)),
        .HALF_64(33'(H64)), .HALF_16(33'(H16)), .HALF_SLOW(33'(HSL)),
        .HALF_T2K(33'(HT2K)), .HALF_T4K(33'(HT4K)), .HALF_T3K2(33'(HT3K2)),
        .HALF_T2K7(33'(HT2K7))
    ) dut (
        .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .toneSelPinA(toneSelPinA),
        .toneSelPinB(toneSelPinB), .rfPowerCtl(rfPowerCtl),
        .alertEnableIn(alertEnableIn), .outBEnableIn(outBEnableIn),
        .refClkOutA(refClkOutA), .refClkOutB(refClkOutB), .toneOut(toneOut),
        .toneOutEnN(toneOutEnN), .battLowFlagOut(battLowFlagOut), .irq(irq)
    );

    ptr_buzzer_model buz (.toneOut(toneOut), .toneOutEnN(toneOutEnN), .buzPin(buzPin));

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail++;
            completeRun();
        end
    end

    task automatic completeRun();
        $display("checks %0d failures %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : completeRun

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "no pready");
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, err);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0, rdat, err);
        chk(rdat, e, "read data");
        chk({31'h0, err}, {31'h0, ee}, "pslverr");
    endtask : rdchk

    function automatic logic pick(input int w);
        case (w)
            0: pick = refClkOutA;
            1: pick = refClkOutB;
            2: pick = buzPin;
            default: pick = toneOutEnN;
        endcase
    endfunction : pick

    // Length of a settled half period, after letting a new selection land
    task automatic halfOf(input int w, output int hc);
        logic v;
        repeat (4) begin
            v = pick(w);
            hc = 0;
            while (pick(w) === v && hc < 200) begin
                @(posedge core_clk);
                hc++;
            end
        end
    endtask : halfOf

    task automatic holdsHigh(input int w, input int n);
        repeat (n) begin
            @(posedge core_clk);
            chk({31'h0, pick(w)}, 32'h1, "level held");
        end
    endtask : holdsHigh

    // One power-up pulse of the receiver, held several cycles
    task automatic pulse(input logic sense);
        @(posedge core_clk);
        toneSelPinB <= sense;
        rfPowerCtl  <= 1'b1;
        repeat (5) @(posedge core_clk);
        rfPowerCtl <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic checkRegs();
        rdchk(`PTR_CTRL_OFS, 32'h3, 1'b0);
        rdchk(`PTR_INTMASK_OFS, 32'h0, 1'b0);
        rdchk(`PTR_INTSTAT_OFS, 32'h0, 1'b0);
        wr(12'h010, 32'hFFFFFFFF);
        rdchk(12'h010, 32'h0, 1'b1);
        rdchk(`PTR_CTRL_OFS, 32'h3, 1'b0);
    endtask : checkRegs

    task automatic checkRefB();
        outBEnableIn <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            cfg = '0;
            cfg.battSensePinMode = 1'b1;
            cfg.outADisableOpt = 1'b1;
            cfg.outBFreqSel = 2'(c);
            cfg.xtal76k = (c == 4);
            wr(`PTR_CTRL_OFS, 32'(cfg));
            halfOf(1, h);
            chk(32'(h), 32'(B_EXP[c]), "output B half period");
        end
        outBEnableIn <= 1'b0;
        repeat (2) @(posedge core_clk);
        holdsHigh(1, 30);
    endtask : checkRefB

    task automatic checkPhase();
        outBEnableIn <= 1'b1;
        cfg = '0;
        cfg.battSensePinMode = 1'b1;
        cfg.outAFreqSel = 2'h1;
        cfg.outBFreqSel = 2'h1;
        cfg.extAddrOpt = 1'b0;
        wr(`PTR_CTRL_OFS, 32'(cfg));
        holdsHigh(0, 40);
        cfg.optWaitDone = 1'b1;
        wr(`PTR_CTRL_OFS, 32'(cfg));
        halfOf(0, h);
        chk(32'(h), 32'(H64), "output A half period");
        repeat (20) begin
            @(posedge core_clk);
            chk({31'h0, refClkOutB}, {31'h0, ~refClkOutA}, "B against A");
        end
        // Disable option set: A must stop once the new word has reached it
        cfg.outADisableOpt = 1'b1;
        wr(`PTR_CTRL_OFS, 32'(cfg));
        @(posedge core_clk);
        holdsHigh(0, 20);
    endtask : checkPhase

    task automatic checkTone();
        alertEnableIn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            {toneSelPinB, toneSelPinA} <= 2'(k);
            halfOf(2, h);
            chk(32'(h), 32'(T_EXP[k]), "tone half period");
            chk({31'h0, toneOut}, 32'h0, "tone data");
        end
        cfg.battSensePinMode = 1'b0;
        wr(`PTR_CTRL_OFS, 32'(cfg));
        {toneSelPinB, toneSelPinA} <= 2'h0;
        halfOf(2, h);
        chk(32'(h), 32'(HT3K2), "tone with forced select");
        apb(1'b0, `PTR_STATUS_OFS, 32'h0, rdat, err);
        chk({31'h0, rdat[1]}, 32'h1, "effective select");
        alertEnableIn <= 1'b0;
        repeat (2) @(posedge core_clk);
        holdsHigh(3, 30);
    endtask : checkTone

    task automatic checkBattery();
        wr(`PTR_INTMASK_OFS, 32'h1);
        repeat (3) pulse(1'b1);
        chk({31'h0, battLowFlagOut}, 32'h0, "flag after three");
        pulse(1'b1);
        chk({31'h0, battLowFlagOut}, 32'h1, "flag after four");
        chk({31'h0, irq}, 32'h1, "irq on rise");
        rdchk(`PTR_INTSTAT_OFS, 32'h1, 1'b0);
        wr(`PTR_INTSTAT_OFS, 32'h1);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        repeat (3) pulse(1'b0);
        chk({31'h0, battLowFlagOut}, 32'h1, "flag kept");
        pulse(1'b0);
        chk({31'h0, battLowFlagOut}, 32'h0, "flag cleared");
        rdchk(`PTR_INTSTAT_OFS, 32'h2, 1'b0);
        chk({31'h0, irq}, 32'h0, "masked event");
    endtask : checkBattery

    // Main sequence
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        toneSelPinA = 1'b1;
        toneSelPinB = 1'b1;
        rfPowerCtl = 1'b0;
        alertEnableIn = 1'b0;
        outBEnableIn = 1'b0;
        nFail = 0;
        totalChecks = 0;
        cycles = 0;
        repeat (2) @(posedge core_clk);
        chk({26'h0, refClkOutA, refClkOutB, toneOutEnN, battLowFlagOut, irq, pready},
            32'h38, "reset outputs");
        nrst <= 1'b1;
        checkRegs();
        checkRefB();
        checkPhase();
        checkTone();
        checkBattery();
        completeRun();
    end
endmodule : ptr_tone_ref_tb

/* verilog/ptr_debounce.sv */
`timescale 1ns/1ps
`include "ptr_defs.svh"

module ptr_debounce (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic sampleStb,
    input  wire logic senseIn,
    output logic      flag
);
    import ptr_pkg::*;

    logic [2:0] highCnt_reg;
    logic [2:0] lowCnt_reg;
    logic       flag_reg;

    // Run lengths of equal samples, four in a row flips the flag
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            highCnt_reg <= '0;
            lowCnt_reg  <= '0;
            flag_reg    <= 1'b0;
        end else if (sampleStb) begin
            if (senseIn) begin
                lowCnt_reg <= '0;
                if (highCnt_reg == `PTR_DEB_LAST) begin
                    flag_reg <= 1'b1;
                end else begin
                    highCnt_reg <= highCnt_reg + 3'h1;
                end
            end else begin
                highCnt_reg <= '0;
                if (lowCnt_reg == `PTR_DEB_LAST) begin
                    flag_reg <= 1'b0;
                end else begin
                    lowCnt_reg <= lowCnt_reg + 3'h1;
                end
            end
        end
    end

    assign flag = flag_reg;

    batt_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(flag_reg) |-> $past(highCnt_reg) == `PTR_DEB_LAST && $past(senseIn))
        else $error("low flag rose early");
    batt_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(flag_reg) |-> $past(lowCnt_reg) == `PTR_DEB_LAST && !$past(senseIn))
        else $error("low flag fell early");
endmodule : ptr_debounce

/* verilog/ptr_defs.svh */
`ifndef PTR_DEFS_SVH
`define PTR_DEFS_SVH

// Core clock and output frequencies
`define PTR_CLK_HZ        64'd200000000
`define PTR_RT_HZ         64'd32768
`define PTR_FAST_32K_HZ   64'd16384
`define PTR_FAST_76K_HZ   64'd19200
`define PTR_REF64_HZ      64'd64
`define PTR_REF16_HZ      64'd16
`define PTR_SLOW_PERIOD_S 64'd60
`define PTR_TONE_2K_DHZ   64'd20000
`define PTR_TONE_4K_DHZ   64'd40000
`define PTR_TONE_3K2_DHZ  64'd32000
`define PTR_TONE_2K7_DHZ  64'd27000

// Half period in core cycles, rounded down
`define PTR_HALF_HZ(f)   (`PTR_CLK_HZ / (64'd2 * (f)))
`define PTR_HALF_DHZ(f)  (`PTR_CLK_HZ * 64'd10 / (64'd2 * (f)))
`define PTR_HALF_SLOW    (`PTR_CLK_HZ * `PTR_SLOW_PERIOD_S / 64'd2)

// Divider and filter
`define PTR_CNT_W        33
`define PTR_DIV_RST_HALF 33'h000000001
`define PTR_DEB_LAST     3'h3

// Register map
`define PTR_ADDR_W       12
`define PTR_CTRL_OFS     12'h000
`define PTR_STATUS_OFS   12'h004
`define PTR_INTSTAT_OFS  12'h008
`define PTR_INTMASK_OFS  12'h00C
`define PTR_CTRL_RST     9'h003
`define PTR_NIRQ         2
`define PTR_IRQ_RISE     0
`define PTR_IRQ_FALL     1

// Select codes
`define PTR_SEL_FAST     2'h0
`define PTR_SEL_64       2'h1
`define PTR_SEL_16       2'h2
`define PTR_SEL_SLOW     2'h3

`endif

/* verilog/ptr_div.sv */
`timescale 1ns/1ps
`include "ptr_defs.svh"

module ptr_div (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic [`PTR_CNT_W-1:0]  halfIn,
    output logic                        phase
);
    import ptr_pkg::*;

    logic [`PTR_CNT_W-1:0] cnt_reg;
    logic [`PTR_CNT_W-1:0] half_reg;
    logic                  phase_reg;
    logic                  terminal;

    // End of a half period
    assign terminal = (cnt_reg >= half_reg - `PTR_DIV_RST_HALF);

    // New half period only taken at a boundary, so no runt pulses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg   <= '0;
            half_reg  <= `PTR_DIV_RST_HALF;
            phase_reg <= 1'b0;
        end else if (terminal) begin
            cnt_reg   <= '0;
            half_reg  <= (halfIn == '0) ? `PTR_DIV_RST_HALF : halfIn;
            phase_reg <= ~phase_reg;
        end else begin
            cnt_reg   <= cnt_reg + `PTR_DIV_RST_HALF;
        end
    end

    assign phase = phase_reg;

    div_toggle_a: assert property (@(posedge core_clk) disable iff (!nrst)
        terminal |=> phase_reg != $past(phase_reg))
        else $error("divider missed its toggle");
    div_steady_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !terminal |=> $stable(phase_reg) && $stable(half_reg))
        else $error("divider changed mid period");
endmodule : ptr_div

/* verilog/ptr_pkg.sv */
package ptr_pkg;
    // Control word, top bit first, bit 0 at the bottom
    typedef struct packed {
        logic       extAddrOpt;
        logic       optWaitDone;
        logic       xtal76k;
        logic [1:0] outBFreqSel;
        logic [1:0] outAFreqSel;
        logic       outADisableOpt;
        logic       battSensePinMode;
    } ptr_ctrl_t;

    // Status word
    typedef struct packed {
        logic tonePhase;
        logic toneSelB;
        logic battLowFlag;
    } ptr_status_t;

    // Register decode result
    typedef enum logic [2:0] {
        PTR_R_CTRL, PTR_R_STATUS, PTR_R_INTSTAT, PTR_R_INTMASK, PTR_R_NONE
    } ptr_reg_t;
endpackage : ptr_pkg

/* verilog/ptr_tone_ref.sv */
// Overview of operation
// - Output B frequency by two-bit select: fast, 64 Hz, 16 Hz, 1/60 Hz.
// - Outputs A and B on equal frequency run in opposite phase.
// - Tone frequency by select pins B,A: 2, 4, 3.2, 2.7 KHz.
// - Select B only used in pin mode 1, else forced high.
// - Pin mode 0 makes the shared pin battery sense, 1 makes it select B.
// - Battery sense sampled on each rise of RF power control.
// - Low flag sets after four high samples, clears after four low.
// - Tone output floats when alert off, else pulls low only.
// - Output B holds high while its enable is low.
// - Output A only runs after the option wait phase ends.
// - Output A disable option: 0 enables, 1 disables.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ptr_defs.svh"

module ptr_tone_ref #(
    parameter logic [32:0] HALF_RT   = 33'(`PTR_HALF_HZ(`PTR_RT_HZ)),
    parameter logic [32:0] HALF_F32  = 33'(`PTR_HALF_HZ(`PTR_FAST_32K_HZ)),
    parameter logic [32:0] HALF_F76  = 33'(`PTR_HALF_HZ(`PTR_FAST_76K_HZ)),
    parameter logic [32:0] HALF_64   = 33'(`PTR_HALF_HZ(`PTR_REF64_HZ)),
    parameter logic [32:0] HALF_16   = 33'(`PTR_HALF_HZ(`PTR_REF16_HZ)),
    parameter logic [32:0] HALF_SLOW = 33'(`PTR_HALF_SLOW),
    parameter logic [32:0] HALF_T2K  = 33'(`PTR_HALF_DHZ(`PTR_TONE_2K_DHZ)),
    parameter logic [32:0] HALF_T4K  = 33'(`PTR_HALF_DHZ(`PTR_TONE_4K_DHZ)),
    parameter logic [32:0] HALF_T3K2 = 33'(`PTR_HALF_DHZ(`PTR_TONE_3K2_DHZ)),
    parameter logic [32:0] HALF_T2K7 = 33'(`PTR_HALF_DHZ(`PTR_TONE_2K7_DHZ))
) (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`PTR_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   toneSelPinA,
    input  wire logic                   toneSelPinB,
    input  wire logic                   rfPowerCtl,
    input  wire logic                   alertEnableIn,
    input  wire logic                   outBEnableIn,
    output logic                        refClkOutA,
    output logic                        refClkOutB,
    output logic                        toneOut,
    output logic                        toneOutEnN,
    output logic                        battLowFlagOut,
    output logic                        irq
);
    import ptr_pkg::*;

    // Register decode, shared by read and write paths
    function automatic ptr_reg_t regDecode(input logic [`PTR_ADDR_W-1:0] a);
        case (a)
            `PTR_CTRL_OFS:    regDecode = PTR_R_CTRL;
            `PTR_STATUS_OFS:  regDecode = PTR_R_STATUS;
            `PTR_INTSTAT_OFS: regDecode = PTR_R_INTSTAT;
            `PTR_INTMASK_OFS: regDecode = PTR_R_INTMASK;
            default:          regDecode = PTR_R_NONE;
        endcase
    endfunction : regDecode

    // Reference select to half period, shared by both outputs
    function automatic logic [32:0] refHalf(input logic [1:0] sel,
                                            input logic [32:0] fast);
        case (sel)
            `PTR_SEL_FAST: refHalf = fast;
            `PTR_SEL_64:   refHalf = HALF_64;
            `PTR_SEL_16:   refHalf = HALF_16;
            `PTR_SEL_SLOW: refHalf = HALF_SLOW;
            default:       refHalf = fast;
        endcase
    endfunction : refHalf

    ptr_ctrl_t              ctrl_reg;
    logic [`PTR_NIRQ-1:0]   intStat_reg;
    logic [`PTR_NIRQ-1:0]   intMask_reg;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   rfPrev_reg;
    logic                   flagPrev_reg;
    logic                   refA_reg;
    logic                   refB_reg;
    logic                   toneOut_reg;
    logic                   toneOutEnN_reg;
    logic                   irq_reg;
    ptr_status_t            status;
    ptr_reg_t               setupSel;
    ptr_reg_t               accessSel;
    logic                   setupPhase;
    logic                   wrStb;
    logic [31:0]            readMux;
    logic                   toneSelB;
    logic                   sampleStb;
    logic                   battLowFlag;
    logic [`PTR_NIRQ-1:0]   events;
    logic [32:0]            halfA;
    logic [32:0]            halfB;
    logic [32:0]            halfTone;
    logic                   phaseA;
    logic                   phaseB;
    logic                   tonePhase;
    logic                   aActive;
    logic                   sameFreq;

    // Bus phase decode
    assign setupPhase = psel & ~penable;
    assign setupSel   = regDecode(paddr);
    assign accessSel  = regDecode(paddr);
    assign wrStb      = psel & penable & pready_reg & pwrite;

    // Status view
    assign status.battLowFlag = battLowFlag;
    assign status.toneSelB    = toneSelB;
    assign status.tonePhase   = tonePhase;

    // Read data selection
    always_comb begin
        readMux = '0;
        case (setupSel)
            PTR_R_CTRL:    readMux = 32'(ctrl_reg);
            PTR_R_STATUS:  readMux = 32'(status);
            PTR_R_INTSTAT: readMux = 32'(intStat_reg);
            PTR_R_INTMASK: readMux = 32'(intMask_reg);
            default:       readMux = '0;
        endcase
    end

    // Slave answers in the first access cycle, no wait states
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setupPhase;
            pslverr_reg <= setupPhase & (setupSel == PTR_R_NONE);
            prdata_reg  <= (setupPhase & ~pwrite) ? readMux : '0;
        end
    end

    // Control word; writes take effect at the access edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= ptr_ctrl_t'(`PTR_CTRL_RST);
        end else if (wrStb && accessSel == PTR_R_CTRL) begin
            ctrl_reg <= ptr_ctrl_t'(pwdata[$bits(ptr_ctrl_t)-1:0]);
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intMask_reg <= '0;
        end else if (wrStb && accessSel == PTR_R_INTMASK) begin
            intMask_reg <= pwdata[`PTR_NIRQ-1:0];
        end
    end

    // Sticky events, write one to clear, a new event wins
    generate
        for (genvar i = 0; i < `PTR_NIRQ; i++) begin : gIrq
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    intStat_reg[i] <= 1'b0;
                end else if (events[i]) begin
                    intStat_reg[i] <= 1'b1;
                end else if (wrStb && accessSel == PTR_R_INTSTAT && pwdata[i]) begin
                    intStat_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(intStat_reg & intMask_reg);
        end
    end

    // Shared pin: select B in mode 1, forced high in mode 0
    assign toneSelB = ctrl_reg.battSensePinMode ? toneSelPinB : 1'b1;

    // One battery sample per rise of RF power control
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rfPrev_reg   <= 1'b0;
            flagPrev_reg <= 1'b0;
        end else begin
            rfPrev_reg   <= rfPowerCtl;
            flagPrev_reg <= battLowFlag;
        end
    end

    assign sampleStb = rfPowerCtl & ~rfPrev_reg & ~ctrl_reg.battSensePinMode;
    assign events[`PTR_IRQ_RISE] = battLowFlag & ~flagPrev_reg;
    assign events[`PTR_IRQ_FALL] = ~battLowFlag & flagPrev_reg;

    // Four-sample filter on the battery sense
    ptr_debounce uDeb (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .sampleStb (sampleStb),
        .senseIn   (toneSelPinB),
        .flag      (battLowFlag)
    );

    // Frequency selection per output
    assign halfA = refHalf(ctrl_reg.outAFreqSel, HALF_RT);
    assign halfB = refHalf(ctrl_reg.outBFreqSel,
                           ctrl_reg.xtal76k ? HALF_F76 : HALF_F32);

    // Tone select, pin B then pin A
    always_comb begin
        case ({toneSelB, toneSelPinA})
            2'h0:    halfTone = HALF_T2K;
            2'h1:    halfTone = HALF_T4K;
            2'h2:    halfTone = HALF_T3K2;
            2'h3:    halfTone = HALF_T2K7;
            default: halfTone = HALF_T2K7;
        endcase
    end

    // Counter dividers off the core clock
    ptr_div uDivA (
        .core_clk (core_clk),
        .nrst     (nrst),
        .halfIn   (halfA),
        .phase    (phaseA)
    );

    ptr_div uDivB (
        .core_clk (core_clk),
        .nrst     (nrst),
        .halfIn   (halfB),
        .phase    (phaseB)
    );

    ptr_div uDivT (
        .core_clk (core_clk),
        .nrst     (nrst),
        .halfIn   (halfTone),
        .phase    (tonePhase)
    );

    // Output A gating and phase relation of B
    assign aActive  = ctrl_reg.optWaitDone & ~ctrl_reg.outADisableOpt;
    assign sameFreq = (ctrl_reg.outAFreqSel == ctrl_reg.outBFreqSel) &&
                      (ctrl_reg.outBFreqSel != `PTR_SEL_FAST);

    // Reference outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            refA_reg <= 1'b1;
            refB_reg <= 1'b1;
        end else begin
            refA_reg <= aActive ? phaseA : 1'b1;
            if (!outBEnableIn) begin
                refB_reg <= 1'b1;
            end else if (sameFreq) begin
                refB_reg <= ~phaseA;
            end else begin
                refB_reg <= phaseB;
            end
        end
    end

    // Open-drain tone: drive low only, enable low while driving
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            toneOut_reg    <= 1'b0;
            toneOutEnN_reg <= 1'b1;
        end else begin
            toneOut_reg    <= 1'b0;
            toneOutEnN_reg <= ~(alertEnableIn & ~tonePhase);
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign refClkOutA     = refA_reg;
    assign refClkOutB     = refB_reg;
    assign toneOut        = toneOut_reg;
    assign toneOutEnN     = toneOutEnN_reg;
    assign battLowFlagOut = battLowFlag;
    assign irq            = irq_reg;

    tone_float_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !alertEnableIn |=> toneOutEnN)
        else $error("tone driven while alert off");
    tone_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
        alertEnableIn && !tonePhase |=> !toneOutEnN && !toneOut)
        else $error("tone not pulled low");
    outb_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !outBEnableIn [*2] |-> refClkOutB)
        else $error("output B not held high");
    outa_wait_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl_reg.optWaitDone |=> refClkOutA)
        else $error("output A ran before wait end");
    phase_split_a: assert property (@(posedge core_clk) disable iff (!nrst)
        outBEnableIn && aActive && sameFreq |=> refClkOutB != refClkOutA)
        else $error("equal outputs share phase");
    selb_force_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl_reg.battSensePinMode |-> toneSelB && halfTone != HALF_T2K
                                       && halfTone != HALF_T4K)
        else $error("select B not forced high");
    sample_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl_reg.battSensePinMode || !$rose(rfPowerCtl) |-> !sampleStb)
        else $error("battery sampled outside power rise");
    freq_b_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl_reg.outBFreqSel == `PTR_SEL_SLOW |-> halfB == HALF_SLOW)
        else $error("output B slow select wrong");
    irq_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
        |(intStat_reg & intMask_reg) |=> irq)
        else $error("interrupt not raised");

    // Bus answer, refusal, sticky event capture, output A disable, shared pin and low tone select
    bus_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
        setupPhase |=> pready)
        else $error("no answer in access cycle");
    bus_error_a: assert property (@(posedge core_clk) disable iff (!nrst)
        setupPhase && setupSel == PTR_R_NONE |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    stat_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
        events != '0 |=> (intStat_reg & $past(events)) == $past(events))
        else $error("interrupt event lost");
    outa_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl_reg.outADisableOpt |=> refClkOutA)
        else $error("output A ran while disabled");
    selb_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrl_reg.battSensePinMode |-> toneSelB == toneSelPinB && !sampleStb)
        else $error("shared pin not used as select");
    tone_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !toneSelB && !toneSelPinA |-> halfTone == HALF_T2K)
        else $error("low select pins not lowest tone");
endmodule : ptr_tone_ref
